// File: tb/cef_host.sv
// Host model of the register port: turns bench requests into one-cycle strobes.
// Assumes requests are one-cycle pulses given at the rising clock edge.
`timescale 1ns/1ps
module cef_host (
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Request from the bench.
    input  wire logic       i_req,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    // Register port strobes.
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd,
    // High in the one cycle where read data stand.
    output logic            o_rvalid
);
    // Strobes last one cycle, so back-to-back requests never merge.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {o_rd, o_wr, o_rvalid, o_addr, o_wdata} <= '0;
        end else begin
            o_rd     <= i_req & ~i_wr;
            o_wr     <= i_req & i_wr;
            o_rvalid <= o_rd;
            o_addr   <= i_addr;
            o_wdata  <= i_wdata;
        end
    end
endmodule : cef_host

// File: tb/testbench.sv
// Self-checking bench of the error-flag bank.
// Assumes the host model drives the register port; events are driven here.
`timescale 1ns/1ps
module testbench;
    import cef_pkg::*;
    logic        I_MCLK = 1'b0, I_SYS_RST = 1'b1, hreq = 1'b0, hwr = 1'b0;
    logic [7:0]  haddr = '0, hwd = '0, rxd = '0, addr, wd, O_RDATA, wdt;
    logic        wr, rd, rv, st, wv, stop, den, done, irq;
    logic [5:0]  fl = '0, nf = '0;
    cef_seq_t    seq = '0, ns = '0;
    cef_rx_evt_t rx = '0, nr = '0;
    cef_com_t    cm[5] = '{CEF_COM_IDLE, CEF_COM_IDLE, CEF_COM_PRE_RECEIVE_DELAY_STATE,
                           CEF_COM_WAITDT, CEF_COM_RECV};
    logic [7:0]  q[$];
    logic [6:0]  p;
    int          num_errors = 0, num_checks = 0, i;
    always #2.5 I_MCLK = ~I_MCLK;
    cef_host HOST (.i_clk(I_MCLK), .i_rst(I_SYS_RST), .i_req(hreq), .i_wr(hwr),
        .i_addr(haddr), .i_wdata(hwd), .o_addr(addr), .o_wdata(wd), .o_wr(wr),
        .o_rd(rd), .o_rvalid(rv));
    cef_top DUT (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(addr), .I_WDATA(wd),
        .I_WR(wr), .I_RD(rd), .O_RDATA(O_RDATA), .I_NVM_DONE(fl[5]), .I_NVM_FAIL(fl[4]),
        .I_FIFO_WR(fl[3]), .I_FIFO_FULL(fl[2]), .I_FIFO_EMPTY(fl[1]),
        .I_FLAGS_APPENDED(fl[0]), .O_FIFO_STORE(st), .I_SEQ(seq), .I_RX(rx),
        .I_RX_DATA(rxd), .O_RX_WVALID(wv), .O_RX_WDATA(wdt), .O_RX_STOP(stop),
        .O_DECODER_EN(den), .O_RX_DONE_IRQ(done), .O_ERR_IRQ(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Read data are compared when they stand, against the oldest note.
    always @(posedge I_MCLK) if (rv) chk(O_RDATA, q.pop_front());
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge I_MCLK);
        hreq  <= 1'b1;
        hwr   <= w;
        haddr <= a;
        hwd   <= d;
        @(posedge I_MCLK);
        hreq  <= 1'b0;
    endtask : bus
    task rd_x(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd_x
    // Applies the noted events for one cycle; outputs are settled on return.
    task go;
        @(posedge I_MCLK);
        seq <= ns;
        rx  <= nr;
        fl  <= nf;
        rxd <= 8'($urandom);
        @(posedge I_MCLK);
        {seq, rx, fl} <= '0;
        {ns, nr, nf} = '0;
        #1;
    endtask : go
    // Each byte leaves one slot later, the last one with the end of frame.
    task frm(input int nb, input int ny, input logic e);
        logic       hv;
        logic [7:0] hb;
        hv = 1'b0;
        hb = 8'h00;
        nr.sof = 1'b1;
        go;
        repeat (nb) begin nr.bit_ok = 1'b1; go; end
        repeat (ny) begin
            nr.byte_ok = 1'b1;
            go;
            chk(8'(wv), 8'(hv));
            if (hv) chk(wdt, hb);
            hv = 1'b1;
            hb = rxd;
        end
        nr.eof = 1'b1;
        go;
        chk(8'(wv), 8'(hv));
        if (hv) chk(wdt, hb);
        chk(8'(done), 8'(e));
    endtask : frm
    task rx_go;
        ns.com = CEF_COM_WAITDT;
        go;
    endtask : rx_go
    task end_sim;
        if (q.size() != 0) num_errors++;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin #20000; num_errors++; end_sim; end
    initial begin
        void'($urandom(81));
        repeat (12) @(posedge I_MCLK);
        I_SYS_RST <= 1'b0;
        rd_x(8'h0a, 8'h00);
        bus(1'b1, 8'h0a, 8'hff);
        rd_x(8'h0a, 8'h00);
        rd_x(8'h55, 8'h00);
        $display("test 1 done");
        nf = 6'h30; go; chk(8'(irq), 8'h0);
        rd_x(8'h0a, 8'h80);
        nf = 6'h20; go; rd_x(8'h0a, 8'h00);
        nf = 6'h0c; go; chk(8'(irq), 8'h1);
        chk(8'(st), 8'h0);
        nf = 6'h08; go; chk(8'(st), 8'h0);
        rd_x(8'h0a, 8'h20);
        rd_x(8'h0a, 8'h20);
        ns.start = 1'b1; go; nf = 6'h08; go; chk(8'(st), 8'h1);
        $display("test 2 done");
        for (i = 0; i < 5; i++) begin
            ns.crc_tx = (i == 0); ns.auth_busy = (i == 1); ns.com = cm[i]; nf = 6'h08;
            go; chk(8'(irq), 8'h1);
            rd_x(8'h0a, 8'h40);
            ns.start = 1'b1; go; rd_x(8'h0a, 8'h00);
        end
        bus(1'b1, 8'h20, 8'h04);
        ns.com = CEF_COM_RECV; nf = 6'h08; go; ns.start = 1'b1; go;
        rd_x(8'h0a, 8'h40);
        nf = 6'h01; go; rd_x(8'h0a, 8'h00);
        bus(1'b1, 8'h20, 8'h00);
        ns.tx_due = 1'b1; nf = 6'h02; go; chk(8'(irq), 8'h1);
        rd_x(8'h0a, 8'h08);
        $display("test 3 done");
        ns.start = 1'b1; ns.kind = CEF_CMD_RECV; go; p = 7'($urandom);
        nr.sof = 1'b1; go;
        nr.coll = 1'b1; nr.coll_pos = p; go; chk(8'(irq), 8'h0);
        rd_x(8'h0a, 8'h04);
        nr.coll = 1'b1; nr.coll_pos = ~p; go; rd_x(8'h21, {1'b1, p});
        rx_go; rd_x(8'h0a, 8'h00);
        nr.coll = 1'b1; nr.coll_in_eof = 1'b1; go; rd_x(8'h0a, 8'h00);
        nr.crc_err = 1'b1; go; chk(8'(den), 8'h1);
        nr.parity_err = 1'b1; go; rd_x(8'h0a, 8'h01);
        for (i = 0; i < 3; i++) begin
            rx_go; nr.sof = 1'b1; go; nr.byte_ok = 1'b1; go;
            nr.stop_err = (i == 0); nr.frame_err = (i == 1); nr.count_err = (i == 2);
            nr.byte_ok = 1'b1; go; chk(8'(stop), 8'h1);
            chk(8'(wv), 8'h0);
            @(posedge I_MCLK); #1 chk(8'(wv), 8'h0);
            rd_x(8'h0a, 8'h02);
        end
        bus(1'b1, 8'h20, 8'h01); rd_x(8'h20, 8'h01);
        rx_go; nr.sof = 1'b1; go;
        nr.coll = 1'b1; go; rd_x(8'h0a, 8'h05);
        nr.eof = 1'b1; go;
        bus(1'b1, 8'h20, 8'h00);
        $display("test 4 done");
        rx_go; frm(3, 0, 1'b0); chk(8'(den), 8'h1);
        rd_x(8'h0a, 8'h10);
        frm(4, 0, 1'b1);
        bus(1'b1, 8'h20, 8'h02); rx_go; rd_x(8'h0a, 8'h00);
        frm(8, 2, 1'b0); chk(8'(den), 8'h1);
        frm(24, 3, 1'b1);
        repeat (4) @(posedge I_MCLK);
        $display("test 5 done");
        end_sim;
    end
endmodule : testbench

// File: verilog/cef_consts.svh
// Constants of the contactless error-flag block: offsets, bit positions, resets, counts.
// Assumes it is included by bare name from the design modules.
//
// Notes on behaviour
// - Bit 7 reflects failure of last nonvolatile command.
// - Bit 6 set on FIFO write while busy.
// - Bit 6 cleared when a new command starts.
// - Multi-frame: bit 6 cleared after flags appended.
// - Bit 5 set on write to full FIFO.
// - Writes ignored while overflow flag is set.
// - Bit 4 set when frame has under 4 bits.
// - Short frames dropped, decoder on, no done.
// - Suppression drops frames under 3 bytes silently.
// - Receive start clears bits 4, 2, 1, 0.
// - Bit 3 set when sending from empty FIFO.
// - Bit 2 on collision, first position recorded.
// - Collision inside end-of-frame sets nothing.
// - Bit 1 on stop bit, framing, count fault.
// - Protocol fault stops reception at once.
// - Protocol fault drops the last received byte.
// - Bit 0 set on parity or CRC failure.
// - Integrity failure does not abort the frame.
// - Collision-as-integrity also sets bit 0.
// - Error interrupt when bits 6,5,3,1,0 set.
`ifndef CEF_CONSTS_SVH
`define CEF_CONSTS_SVH
`define CEF_ERR_OFS      8'h0a
`define CEF_CFG_OFS      8'h20
`define CEF_CPOS_OFS     8'h21
`define CEF_ERR_RST      8'h00
`define CEF_CFG_RST      3'h0
`define CEF_CPOS_RST     8'h00
`define CEF_B_NVM        7
`define CEF_B_WRC        6
`define CEF_B_OVF        5
`define CEF_B_SHORT      4
`define CEF_B_EMPTY      3
`define CEF_B_COLL       2
`define CEF_B_PROT       1
`define CEF_B_INTEG      0
`define CEF_RX_CLR_MASK  8'h17
`define CEF_IRQ_MASK     8'h6b
`define CEF_C_COLLINT    0
`define CEF_C_NOISE      1
`define CEF_C_MULTI      2
`define CEF_MIN_BITS     3'h4
`define CEF_MIN_BYTES    2'h3
`endif

// File: verilog/cef_frame_filter.sv
// Frame length filter: counts bits and bytes of a frame and judges it at its end.
// Assumes sof, bit_ok, byte_ok and eof are gated one-cycle pulses of one frame.
`timescale 1ns/1ps
`include "cef_consts.svh"
module cef_frame_filter
    import cef_pkg::*;
(
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Frame events.
    input  wire logic i_sof,
    input  wire logic i_bit,
    input  wire logic i_byte,
    input  wire logic i_eof,
    input  wire logic i_noise_en,
    // Verdicts.
    output logic      o_short,
    output logic      o_done
);
    logic [2:0] bits_r,  bits_nxt;   // Saturating bit count.
    logic [1:0] bytes_r, bytes_nxt;  // Saturating byte count.
    logic       short_nxt, done_nxt;
    logic       is_short, is_noise;

    // The counts saturate at the thresholds; nothing beyond is needed.
    always_comb begin
        bits_nxt  = bits_r;
        bytes_nxt = bytes_r;
        is_short  = (bits_r < `CEF_MIN_BITS);
        is_noise  = i_noise_en && (bytes_r < `CEF_MIN_BYTES);
        short_nxt = 1'b0;
        done_nxt  = 1'b0;
        if (i_sof) begin
            bits_nxt  = 3'h0;
            bytes_nxt = 2'h0;
        end else begin
            if (i_bit && bits_r != `CEF_MIN_BITS) begin
                bits_nxt = bits_r + 3'h1;
            end
            if (i_byte && bytes_r != `CEF_MIN_BYTES) begin
                bytes_nxt = bytes_r + 2'h1;
            end
        end
        // Short and noise frames vanish without a done pulse.
        if (i_eof) begin
            short_nxt = is_short;
            done_nxt  = !is_short && !is_noise;
        end
    end

    // Register stage.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bits_r  <= 3'h0;
            bytes_r <= 2'h0;
            o_short <= 1'b0;
            o_done  <= 1'b0;
        end else begin
            bits_r  <= bits_nxt;
            bytes_r <= bytes_nxt;
            o_short <= short_nxt;
            o_done  <= done_nxt;
        end
    end

    AST_SHORT_DROP: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_eof && !i_sof && bits_r < `CEF_MIN_BITS) |=> (o_short && !o_done))
        else $error("short frame not dropped");
    AST_NOISE_DROP: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_eof && !i_sof && i_noise_en && bytes_r < `CEF_MIN_BYTES) |=> !o_done)
        else $error("noise frame reported done");
endmodule : cef_frame_filter

// File: verilog/cef_pkg.sv
// Types shared by the contactless error-flag block.
// Assumes the constants header is on the include path.
package cef_pkg;
    // Transceiver phase codes as reported by the sequencer.
    typedef enum logic [2:0] {
        CEF_COM_IDLE   = 3'h0,
        CEF_COM_TXWAIT = 3'h1,
        CEF_COM_TX     = 3'h3,
        CEF_COM_PRE_RECEIVE_DELAY_STATE = 3'h5,
        CEF_COM_WAITDT = 3'h6,
        CEF_COM_RECV   = 3'h7
    } cef_com_t;
    // Kind of command being started.
    typedef enum logic [1:0] {
        CEF_CMD_OTHER = 2'h0,
        CEF_CMD_RECV  = 2'h1,
        CEF_CMD_TRCV  = 2'h3,
        CEF_CMD_AUTH  = 2'h2
    } cef_cmd_kind_t;
    // Receive-path state, Gray along idle, frame, halted.
    typedef enum logic [1:0] {
        CEF_RX_IDLE  = 2'h0,
        CEF_RX_FRAME = 2'h1,
        CEF_RX_HALT  = 2'h3
    } cef_rx_st_t;
    // Command sequencer events.
    typedef struct packed {
        logic          start;
        cef_cmd_kind_t kind;
        logic          auth_busy;
        logic          crc_tx;
        logic          tx_due;
        cef_com_t      com;
    } cef_seq_t;
    // Receive decoder events, one-cycle pulses except coll_pos.
    typedef struct packed {
        logic       sof;
        logic       bit_ok;
        logic       byte_ok;
        logic       eof;
        logic       coll;
        logic       coll_in_eof;
        logic [6:0] coll_pos;
        logic       stop_err;
        logic       frame_err;
        logic       count_err;
        logic       parity_err;
        logic       crc_err;
    } cef_rx_evt_t;
endpackage : cef_pkg

// File: verilog/cef_top.sv
// Error-flag bank of the contactless transceive path, with its register port.
// Assumes sequencer, decoder and FIFO events are synchronous one-cycle pulses.
`timescale 1ns/1ps
`include "cef_consts.svh"
module cef_top
    import cef_pkg::*;
(
    // Clock and reset.
    input  wire logic        I_MCLK,
    input  wire logic        I_SYS_RST,
    // Register port.
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [7:0]  O_RDATA,
    // Nonvolatile sequencer.
    input  wire logic        I_NVM_DONE,
    input  wire logic        I_NVM_FAIL,
    // Host FIFO write side.
    input  wire logic        I_FIFO_WR,
    input  wire logic        I_FIFO_FULL,
    input  wire logic        I_FIFO_EMPTY,
    input  wire logic        I_FLAGS_APPENDED,
    output logic             O_FIFO_STORE,
    // Command sequencer.
    input  wire cef_seq_t    I_SEQ,
    // Receive decoder.
    input  wire cef_rx_evt_t I_RX,
    input  wire logic [7:0]  I_RX_DATA,
    output logic             O_RX_WVALID,
    output logic      [7:0]  O_RX_WDATA,
    output logic             O_RX_STOP,
    output logic             O_DECODER_EN,
    output logic             O_RX_DONE_IRQ,
    // Error interrupt request.
    output logic             O_ERR_IRQ
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);

    ////////////////////////////////////////////////////////////////////////////////
    // Event decode.

    logic       wr_conflict;  // Host write while FIFO belongs to the RF side.
    logic       rx_start;     // Start of a receive phase.
    logic       wrc_clr;      // Clearing moment of the write-conflict flag.
    logic       prot_err;     // Any protocol fault of the current frame.
    logic       in_frame;     // Receive path is taking a frame.
    logic       coll_ok;      // Collision outside the end-of-frame symbol.
    cef_com_t   com_prev_r;   // Phase of the previous cycle.
    cef_rx_st_t st_r, st_nxt; // Receive path state.
    logic [2:0] cfg_r, cfg_nxt;
    logic       flt_sof, flt_eof, flt_short, flt_done; // Frame judge strobes and verdicts.

    // Phase decode; a transceive starts receiving when it enters wait-for-data.
    always_comb begin
        wr_conflict = I_FIFO_WR && (I_SEQ.crc_tx || I_SEQ.auth_busy ||
                      I_SEQ.com == CEF_COM_PRE_RECEIVE_DELAY_STATE || I_SEQ.com == CEF_COM_WAITDT ||
                      I_SEQ.com == CEF_COM_RECV);
        rx_start    = (I_SEQ.start && I_SEQ.kind == CEF_CMD_RECV) ||
                      (I_SEQ.com == CEF_COM_WAITDT && com_prev_r != CEF_COM_WAITDT);
        // With multi-frame reception the flag must survive until it was appended.
        wrc_clr     = cfg_r[`CEF_C_MULTI] ? I_FLAGS_APPENDED : I_SEQ.start;
        in_frame    = (st_r == CEF_RX_FRAME);
        prot_err    = in_frame &&
                      (I_RX.stop_err || I_RX.frame_err || I_RX.count_err);
        coll_ok     = in_frame && I_RX.coll && !I_RX.coll_in_eof;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration register and phase history.

    // Only the three low bits exist; the rest of the byte reads zero.
    always_comb begin
        cfg_nxt = cfg_r;
        if (I_WR && I_ADDR == `CEF_CFG_OFS) begin
            cfg_nxt = I_WDATA[2:0];
        end
    end

    // Register stage.
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            cfg_r      <= `CEF_CFG_RST;
            com_prev_r <= CEF_COM_IDLE;
        end else begin
            cfg_r      <= cfg_nxt;
            com_prev_r <= I_SEQ.com;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Error flags and collision position.

    logic [7:0] flags_r, flags_nxt;  // The error flag register.
    logic [7:0] set_v;               // Set terms of this cycle.
    logic [7:0] clr_v;               // Clear terms of this cycle.
    logic [7:0] cpos_r, cpos_nxt;    // Valid bit and first collision position.
    logic       irq_nxt;

    // Set wins over clear, so no event is lost at a clearing moment.
    always_comb begin
        set_v = 8'h00;
        clr_v = 8'h00;
        set_v[`CEF_B_WRC]   = wr_conflict;
        set_v[`CEF_B_OVF]   = I_FIFO_WR && I_FIFO_FULL;
        set_v[`CEF_B_SHORT] = flt_short;
        set_v[`CEF_B_EMPTY] = I_SEQ.tx_due && I_FIFO_EMPTY;
        set_v[`CEF_B_COLL]  = coll_ok;
        set_v[`CEF_B_PROT]  = prot_err;
        set_v[`CEF_B_INTEG] = (in_frame && (I_RX.parity_err || I_RX.crc_err)) ||
                              (coll_ok && cfg_r[`CEF_C_COLLINT]);
        if (rx_start) begin
            clr_v = `CEF_RX_CLR_MASK;
        end
        clr_v[`CEF_B_WRC] = wrc_clr;
        // Overflow and empty-transmit last until the next command.
        clr_v[`CEF_B_OVF]   = I_SEQ.start;
        clr_v[`CEF_B_EMPTY] = I_SEQ.start;
        flags_nxt = (flags_r & ~clr_v) | set_v;
        // The nonvolatile bit mirrors the verdict of the last command.
        if (I_NVM_DONE) begin
            flags_nxt[`CEF_B_NVM] = I_NVM_FAIL;
        end
        // Only the first collision of a phase records its position.
        cpos_nxt = rx_start ? `CEF_CPOS_RST : cpos_r;
        if (coll_ok && !cpos_r[7]) begin
            cpos_nxt = {1'b1, I_RX.coll_pos};
        end
        irq_nxt = |(set_v & ~flags_r & `CEF_IRQ_MASK);
    end

    // Register stage.
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            flags_r   <= `CEF_ERR_RST;
            cpos_r    <= `CEF_CPOS_RST;
            O_ERR_IRQ <= 1'b0;
        end else begin
            flags_r   <= flags_nxt;
            cpos_r    <= cpos_nxt;
            O_ERR_IRQ <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Host FIFO write gate.

    logic store_nxt;

    // Once overflow is flagged every write is dropped, so stored data stays intact.
    always_comb begin
        store_nxt = I_FIFO_WR && !I_FIFO_FULL && !flags_r[`CEF_B_OVF];
    end

    // Register stage.
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_FIFO_STORE <= 1'b0;
        end else begin
            O_FIFO_STORE <= store_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive path: frame state, one-byte hold and decoder enable.

    logic       hold_vld_r, hold_vld_nxt;  // A byte waits in the hold.
    logic [7:0] hold_r, hold_nxt;          // Most recent received byte.
    logic       wv_nxt, stop_nxt, dec_nxt;
    logic [7:0] wd_nxt;

    // Each byte waits one slot so a protocol fault can still withdraw it.
    always_comb begin
        st_nxt       = st_r;
        hold_vld_nxt = hold_vld_r;
        hold_nxt     = hold_r;
        wv_nxt       = 1'b0;
        wd_nxt       = hold_r;
        stop_nxt     = 1'b0;
        dec_nxt      = O_DECODER_EN;
        flt_sof      = 1'b0;
        flt_eof      = 1'b0;
        if (rx_start) begin
            dec_nxt = 1'b1;
        end
        case (st_r)
            CEF_RX_IDLE: begin
                if (I_RX.sof) begin
                    st_nxt       = CEF_RX_FRAME;
                    flt_sof      = 1'b1;
                    hold_vld_nxt = 1'b0;
                end
            end
            CEF_RX_FRAME: begin
                if (prot_err) begin
                    st_nxt       = CEF_RX_HALT;
                    hold_vld_nxt = 1'b0;
                    stop_nxt     = 1'b1;
                    dec_nxt      = 1'b0;
                end else begin
                    // Integrity faults do not stop the frame.
                    if (I_RX.byte_ok) begin
                        wv_nxt       = hold_vld_r;
                        hold_nxt     = I_RX_DATA;
                        hold_vld_nxt = 1'b1;
                    end
                    if (I_RX.eof) begin
                        st_nxt       = CEF_RX_IDLE;
                        flt_eof      = 1'b1;
                        wv_nxt       = hold_vld_r || I_RX.byte_ok;
                        wd_nxt       = I_RX.byte_ok ? I_RX_DATA : hold_r;
                        hold_vld_nxt = 1'b0;
                    end
                end
            end
            CEF_RX_HALT: begin
                // Only a new receive phase revives the path.
                if (rx_start) begin
                    st_nxt = CEF_RX_IDLE;
                end
            end
            default: begin
                st_nxt = CEF_RX_IDLE;
            end
        endcase
        // A short or noise frame leaves the decoder running.
        if (flt_done) begin
            dec_nxt = 1'b0;
        end
    end

    // Register stage.
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            st_r         <= CEF_RX_IDLE;
            hold_vld_r   <= 1'b0;
            hold_r       <= 8'h00;
            O_RX_WVALID  <= 1'b0;
            O_RX_WDATA   <= 8'h00;
            O_RX_STOP    <= 1'b0;
            O_DECODER_EN <= 1'b0;
        end else begin
            st_r         <= st_nxt;
            hold_vld_r   <= hold_vld_nxt;
            hold_r       <= hold_nxt;
            O_RX_WVALID  <= wv_nxt;
            O_RX_WDATA   <= wd_nxt;
            O_RX_STOP    <= stop_nxt;
            O_DECODER_EN <= dec_nxt;
        end
    end

    // Frame length judge; its done pulse is the receive-done request.
    cef_frame_filter u_filter (
        .i_clk      (I_MCLK),
        .i_rst      (I_SYS_RST),
        .i_sof      (flt_sof),
        .i_bit      (in_frame && I_RX.bit_ok),
        .i_byte     (in_frame && I_RX.byte_ok),
        .i_eof      (flt_eof),
        .i_noise_en (cfg_r[`CEF_C_NOISE]),
        .o_short    (flt_short),
        .o_done     (flt_done)
    );
    assign O_RX_DONE_IRQ = flt_done;

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port; reads have no side effect on any flag.

    logic [7:0] rdata_nxt;

    // Unmapped addresses read zero.
    always_comb begin
        rdata_nxt = 8'h00;
        if (I_RD) begin
            case (I_ADDR)
                `CEF_ERR_OFS:  rdata_nxt = flags_r;
                `CEF_CFG_OFS:  rdata_nxt = {5'h00, cfg_r};
                `CEF_CPOS_OFS: rdata_nxt = cpos_r;
                default:       rdata_nxt = 8'h00;
            endcase
        end
    end

    // Register stage.
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_RDATA <= 8'h00;
        end else begin
            O_RDATA <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_prot_hit;
        in_frame && (I_RX.stop_err || I_RX.frame_err || I_RX.count_err);
    endsequence
    sequence s_halted_quiet;
        (st_r == CEF_RX_HALT && !O_RX_WVALID && O_RX_STOP) ##1 !O_RX_WVALID;
    endsequence

    AST_NVM_FAIL: assert property (I_NVM_DONE |=> flags_r[7] == $past(I_NVM_FAIL))
        else $error("nonvolatile flag wrong");
    AST_WRC_SET: assert property (wr_conflict |=> flags_r[6])
        else $error("write conflict not flagged");
    AST_WRC_CLR: assert property ((I_SEQ.start && !cfg_r[2] && !wr_conflict)
        |=> !flags_r[6]) else $error("write conflict not cleared");
    AST_WRC_MULTI: assert property ((cfg_r[2] && flags_r[6] && !I_FLAGS_APPENDED)
        |=> flags_r[6]) else $error("write conflict cleared early");
    AST_OVF_DROP: assert property ((I_FIFO_WR && (I_FIFO_FULL || flags_r[5]))
        |=> (!O_FIFO_STORE && (flags_r[5] || $past(I_SEQ.start && !I_FIFO_FULL))))
        else $error("overflow write stored");
    AST_RX_CLR: assert property ((rx_start && set_v == 8'h00)
        |=> (flags_r & `CEF_RX_CLR_MASK) == 8'h00) else $error("rx flags kept");
    AST_EMPTY: assert property ((I_SEQ.tx_due && I_FIFO_EMPTY) |=> flags_r[3])
        else $error("empty transmit not flagged");
    AST_COLL: assert property ((in_frame && I_RX.coll)
        |=> flags_r[2] == ($past(I_RX.coll_in_eof) ? ($past(flags_r[2]) && !$past(rx_start))
        : 1'b1)) else $error("collision flag wrong");
    AST_PROT_STOP: assert property (s_prot_hit |=> s_halted_quiet)
        else $error("reception not stopped");
    AST_INTEG: assert property ((in_frame && I_RX.parity_err && !prot_err && !I_RX.eof)
        |=> (flags_r[0] && st_r == CEF_RX_FRAME)) else $error("integrity handling wrong");
    AST_COLL_INT: assert property ((coll_ok && cfg_r[0]) |=> flags_r[0])
        else $error("collision not counted as integrity");
    AST_IRQ: assert property ((|((flags_r & ~$past(flags_r)) & `CEF_IRQ_MASK))
        |-> O_ERR_IRQ) else $error("error irq missing");
endmodule : cef_top
